/* File: src/lscr_pkg.sv */
// Purpose: Shared constants and types for the emitter slot control register bank
// Assumes: 16-bit registers reached over the device host register port
// Notes:   Field positions and reset values for the RTL live here; the dv files repeat them as literals
package lscr_pkg;
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 16;
  localparam logic [7:0]  SLOT_SEL_ADDR  = 8'h14;
  localparam logic [7:0]  EM3_CUR_ADDR   = 8'h22;
  localparam logic [7:0]  EM1_CUR_ADDR   = 8'h23;
  // Field positions (low bit)
  localparam int          SLOT_A_EMIT_LSB = 0;
  localparam int          SLOT_B_EMIT_LSB = 2;
  localparam int          SLOT_A_DET_LSB  = 4;
  localparam int          SLOT_B_DET_LSB  = 8;
  localparam int          SCALE_BIT       = 13;
  localparam int          EDGE_LSB        = 4;
  localparam int          COARSE_LSB      = 0;
  // Reset values
  localparam logic [1:0]  SLOT_A_EMIT_RST = 2'h1;
  localparam logic [1:0]  SLOT_B_EMIT_RST = 2'h0;
  localparam logic [3:0]  SLOT_A_DET_RST  = 4'h4;
  localparam logic [3:0]  SLOT_B_DET_RST  = 4'h5;
  localparam logic [15:0] SLOT_SEL_RST    = 16'h0541;
  localparam logic [15:0] CUR_CFG_RST     = 16'h3000;
  localparam logic [1:0]  EMIT_NONE       = 2'h0;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } lscr_req_t;

  typedef struct packed {
    logic       strength_full;
    logic [2:0] edge_rate;
    logic [3:0] coarse_current;
  } lscr_drv_t;

  typedef struct packed {
    logic [3:0] emitter_pulse;
    logic       detector_pulse;
    logic [3:0] detector_select;
  } lscr_slot_t;
endpackage : lscr_pkg

/* File: src/lscr_slot_decode.sv */
// Purpose: Turns one slot's emitter and detector select codes into drive enables
// Assumes: Purely combinational; caller registers the result
// Notes:   One-hot emitter vector, bit 0 unused
`timescale 1ns/1ps
`default_nettype none
module lscr_slot_decode (
  input  wire logic [1:0]         i_emit_sel, // Emitter select code
  input  wire logic [3:0]         i_det_sel,  // Detector connection select
  output var  lscr_pkg::lscr_slot_t o_slot    // Decoded slot drive
);
  always_comb begin
    o_slot                 = '0;
    o_slot.detector_select = i_det_sel;
    if (i_emit_sel == lscr_pkg::EMIT_NONE) begin
      o_slot.detector_pulse = 1'b1;
    end else begin
      o_slot.emitter_pulse[i_emit_sel] = 1'b1;
    end
  end
endmodule // lscr_slot_decode
`default_nettype wire

/* File: src/lscr_top.sv */
// What this block does
// - Slot A emitter select, bits 1:0, codes 1-3 pick emitters, reset 1
// - Slot B emitter select, bits 3:2, same codes, reset 0
// - Code 0 pulses the photodiode connection instead of any emitter
// - Slot A photodiode select, bits 7:4, reset 4
// - Slot B photodiode select, bits 11:8, reset 5
// - Emitter 3 bit 13 scale: 1 full, 0 ten percent low power, reset 1
// - Emitter 1 bit 13 scale: same meaning, reset 1
// - Emitter 3 slew rate, bits 6:4, 0 slowest, 7 fastest, reset 0
// - Emitter 3 coarse current, bits 3:0, reset 0
// - Emitter 3 peak current is coarse times fine times scale terms
// - Emitter 1 slew rate, bits 6:4, reset 0
// - Emitter 1 coarse current, bits 3:0, reset 0
//
// Purpose: Emitter slot control register bank with decoded driver settings
// Assumes: Host port delivers one-cycle write/read strobes synchronous to i_clk
// Notes:   Read data valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module lscr_top (
  input  wire logic                  i_clk,         // 25 MHz system clock
  input  wire logic                  i_arst_n,      // Async reset, active low
  input  wire lscr_pkg::lscr_req_t   i_req,         // Host register request
  output logic [lscr_pkg::DATA_W-1:0] o_rdata,      // Read data
  output logic                       o_rvalid,      // Read data valid pulse
  output lscr_pkg::lscr_slot_t       o_slot_a,      // Slot A drive decode
  output lscr_pkg::lscr_slot_t       o_slot_b,      // Slot B drive decode
  output lscr_pkg::lscr_drv_t        o_emitter3,    // Emitter 3 driver settings
  output lscr_pkg::lscr_drv_t        o_emitter1     // Emitter 1 driver settings
);
  // Field widths of the map; the decoder ports are sized to match
  localparam int EMIT_W   = 2;
  localparam int DET_W    = 4;
  localparam int EDGE_W   = 3;
  localparam int COARSE_W = 4;
  localparam int NUM_SLOT = 2;
  localparam int NUM_EMIT = 2;

  // Output reset images come from the register reset fields, so they cannot drift apart
  localparam logic       A_DET_PULSE_RST = (lscr_pkg::SLOT_A_EMIT_RST == lscr_pkg::EMIT_NONE);
  localparam logic       B_DET_PULSE_RST = (lscr_pkg::SLOT_B_EMIT_RST == lscr_pkg::EMIT_NONE);
  localparam logic [3:0] A_PULSE_RST     = A_DET_PULSE_RST ? 4'h0 : 4'(4'h1 << lscr_pkg::SLOT_A_EMIT_RST);
  localparam logic [3:0] B_PULSE_RST     = B_DET_PULSE_RST ? 4'h0 : 4'(4'h1 << lscr_pkg::SLOT_B_EMIT_RST);
  localparam lscr_pkg::lscr_slot_t SLOT_A_OUT_RST = '{
    emitter_pulse:   A_PULSE_RST,
    detector_pulse:  A_DET_PULSE_RST,
    detector_select: lscr_pkg::SLOT_A_DET_RST
  };
  localparam lscr_pkg::lscr_slot_t SLOT_B_OUT_RST = '{
    emitter_pulse:   B_PULSE_RST,
    detector_pulse:  B_DET_PULSE_RST,
    detector_select: lscr_pkg::SLOT_B_DET_RST
  };
  localparam lscr_pkg::lscr_drv_t EMIT_OUT_RST = '{
    strength_full:  lscr_pkg::CUR_CFG_RST[lscr_pkg::SCALE_BIT],
    edge_rate:      lscr_pkg::CUR_CFG_RST[lscr_pkg::EDGE_LSB +: EDGE_W],
    coarse_current: lscr_pkg::CUR_CFG_RST[lscr_pkg::COARSE_LSB +: COARSE_W]
  };

  // Refuse a package that no longer fits the word, the ports or the reset word
  if (lscr_pkg::DATA_W != 16) begin : g_chk_data_w
    $error("register word must be 16 bits wide");
  end
  if (lscr_pkg::ADDR_W != 8) begin : g_chk_addr_w
    $error("register address must be 8 bits wide");
  end
  if (lscr_pkg::SLOT_SEL_ADDR == lscr_pkg::EM3_CUR_ADDR ||
      lscr_pkg::SLOT_SEL_ADDR == lscr_pkg::EM1_CUR_ADDR ||
      lscr_pkg::EM3_CUR_ADDR  == lscr_pkg::EM1_CUR_ADDR) begin : g_chk_addr
    $error("register offsets must differ");
  end
  if (lscr_pkg::SLOT_A_EMIT_LSB + EMIT_W > lscr_pkg::SLOT_B_EMIT_LSB) begin : g_chk_emit_a
    $error("slot A emitter field overlaps slot B");
  end
  if (lscr_pkg::SLOT_B_EMIT_LSB + EMIT_W > lscr_pkg::SLOT_A_DET_LSB) begin : g_chk_emit_b
    $error("slot B emitter field overlaps slot A detector field");
  end
  if (lscr_pkg::SLOT_A_DET_LSB + DET_W > lscr_pkg::SLOT_B_DET_LSB) begin : g_chk_det_a
    $error("slot A detector field overlaps slot B");
  end
  if (lscr_pkg::SLOT_B_DET_LSB + DET_W > lscr_pkg::DATA_W) begin : g_chk_det_b
    $error("slot B detector field leaves the word");
  end
  if (lscr_pkg::COARSE_LSB + COARSE_W > lscr_pkg::EDGE_LSB) begin : g_chk_coarse
    $error("coarse current field overlaps edge rate");
  end
  if (lscr_pkg::EDGE_LSB + EDGE_W > lscr_pkg::SCALE_BIT ||
      lscr_pkg::SCALE_BIT >= lscr_pkg::DATA_W) begin : g_chk_edge
    $error("edge rate or scale bit out of place");
  end
  if (lscr_pkg::SLOT_SEL_RST[lscr_pkg::SLOT_A_EMIT_LSB +: EMIT_W] != lscr_pkg::SLOT_A_EMIT_RST ||
      lscr_pkg::SLOT_SEL_RST[lscr_pkg::SLOT_B_EMIT_LSB +: EMIT_W] != lscr_pkg::SLOT_B_EMIT_RST) begin : g_rst_emit
    $error("slot select reset word disagrees with emitter reset codes");
  end
  if (lscr_pkg::SLOT_SEL_RST[lscr_pkg::SLOT_A_DET_LSB +: DET_W] != lscr_pkg::SLOT_A_DET_RST ||
      lscr_pkg::SLOT_SEL_RST[lscr_pkg::SLOT_B_DET_LSB +: DET_W] != lscr_pkg::SLOT_B_DET_RST) begin : g_rst_det
    $error("slot select reset word disagrees with detector reset codes");
  end

  logic [lscr_pkg::DATA_W-1:0] slot_sel;
  logic [lscr_pkg::DATA_W-1:0] next_slot_sel;
  logic [lscr_pkg::DATA_W-1:0] em3_cur;
  logic [lscr_pkg::DATA_W-1:0] next_em3_cur;
  logic [lscr_pkg::DATA_W-1:0] em1_cur;
  logic [lscr_pkg::DATA_W-1:0] next_em1_cur;
  logic [lscr_pkg::DATA_W-1:0] next_rdata;
  logic                        next_rvalid;
  logic                        wr_slot_sel;
  logic                        wr_em3_cur;
  logic                        wr_em1_cur;
  lscr_pkg::lscr_slot_t        slot_dec [NUM_SLOT];
  lscr_pkg::lscr_slot_t        next_slot_a;
  lscr_pkg::lscr_slot_t        next_slot_b;
  logic [lscr_pkg::DATA_W-1:0] emit_word [NUM_EMIT];
  lscr_pkg::lscr_drv_t         emit_drv  [NUM_EMIT];
  lscr_pkg::lscr_drv_t         next_em3;
  lscr_pkg::lscr_drv_t         next_em1;

  // Address decode; unmapped writes fall through and change nothing
  always_comb begin
    wr_slot_sel = i_req.wr && (i_req.addr == lscr_pkg::SLOT_SEL_ADDR);
    wr_em3_cur  = i_req.wr && (i_req.addr == lscr_pkg::EM3_CUR_ADDR);
    wr_em1_cur  = i_req.wr && (i_req.addr == lscr_pkg::EM1_CUR_ADDR);
  end

  // Reserved bits are stored as written; the host owns their correctness
  always_comb begin
    next_slot_sel = slot_sel;
    next_em3_cur  = em3_cur;
    next_em1_cur  = em1_cur;
    if (wr_slot_sel) begin
      next_slot_sel = i_req.wdata;
    end
    if (wr_em3_cur) begin
      next_em3_cur = i_req.wdata;
    end
    if (wr_em1_cur) begin
      next_em1_cur = i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot_sel <= lscr_pkg::SLOT_SEL_RST;
      em3_cur  <= lscr_pkg::CUR_CFG_RST;
      em1_cur  <= lscr_pkg::CUR_CFG_RST;
    end else begin
      slot_sel <= next_slot_sel;
      em3_cur  <= next_em3_cur;
      em1_cur  <= next_em1_cur;
    end
  end

  // Same-cycle read and write of one register returns the old word
  always_comb begin
    next_rvalid = i_req.rd;
    next_rdata  = '0;
    if (i_req.rd) begin
      case (i_req.addr)
        lscr_pkg::SLOT_SEL_ADDR: next_rdata = slot_sel;
        lscr_pkg::EM3_CUR_ADDR:  next_rdata = em3_cur;
        lscr_pkg::EM1_CUR_ADDR:  next_rdata = em1_cur;
        default:                 next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata  <= '0;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata  <= next_rdata;
      o_rvalid <= next_rvalid;
    end
  end

  // One decoder per time slot; slot 0 is A, slot 1 is B
  for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
    localparam int EMIT_LSB = (s == 0) ? lscr_pkg::SLOT_A_EMIT_LSB : lscr_pkg::SLOT_B_EMIT_LSB;
    localparam int DET_LSB  = (s == 0) ? lscr_pkg::SLOT_A_DET_LSB : lscr_pkg::SLOT_B_DET_LSB;
    lscr_slot_decode u_dec (
      .i_emit_sel (slot_sel[EMIT_LSB +: EMIT_W]),
      .i_det_sel  (slot_sel[DET_LSB +: DET_W]),
      .o_slot     (slot_dec[s])
    );
  end

  always_comb begin
    next_slot_a = slot_dec[0];
    next_slot_b = slot_dec[1];
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_slot_a <= SLOT_A_OUT_RST;
      o_slot_b <= SLOT_B_OUT_RST;
    end else begin
      o_slot_a <= next_slot_a;
      o_slot_b <= next_slot_b;
    end
  end

  // Codes go out raw; the analog driver forms coarse x fine x scale
  always_comb begin
    emit_word[0] = em3_cur;
    emit_word[1] = em1_cur;
  end

  // Entry 0 is emitter 3, entry 1 is emitter 1
  for (genvar e = 0; e < NUM_EMIT; e++) begin : g_emit
    assign emit_drv[e] = '{
      strength_full:  emit_word[e][lscr_pkg::SCALE_BIT],
      edge_rate:      emit_word[e][lscr_pkg::EDGE_LSB +: EDGE_W],
      coarse_current: emit_word[e][lscr_pkg::COARSE_LSB +: COARSE_W]
    };
  end

  always_comb begin
    next_em3 = emit_drv[0];
    next_em1 = emit_drv[1];
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_emitter3 <= EMIT_OUT_RST;
      o_emitter1 <= EMIT_OUT_RST;
    end else begin
      o_emitter3 <= next_em3;
      o_emitter1 <= next_em1;
    end
  end
endmodule // lscr_top
`default_nettype wire

/* File: dv/lscr_top_asserts.sv */
// Purpose: Port checks for the slot control register bank
// Assumes: Outputs follow a write two edges later
// Notes:   Bound to every lscr_top
`timescale 1ns/1ps
`default_nettype none
module lscr_top_asserts (
  input wire logic                        i_clk,      // Clock
  input wire logic                        i_arst_n,   // Reset
  input wire lscr_pkg::lscr_req_t         i_req,      // Request
  input wire logic [lscr_pkg::DATA_W-1:0] o_rdata,    // Read data
  input wire logic                        o_rvalid,   // Read valid
  input wire lscr_pkg::lscr_slot_t        o_slot_a,   // Slot A
  input wire lscr_pkg::lscr_slot_t        o_slot_b,   // Slot B
  input wire lscr_pkg::lscr_drv_t         o_emitter3, // Emitter 3
  input wire lscr_pkg::lscr_drv_t         o_emitter1  // Emitter 1
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic [15:0] w1;
  logic [15:0] w2;
  always_ff @(posedge i_clk) begin
    w1 <= i_req.wdata;
    w2 <= w1;
  end
  function automatic logic [8:0] dec(input logic [1:0] e, input logic [3:0] d);
    return {(4'h1 << e) & 4'he, e == 2'h0, d};
  endfunction
  rd_answer_a: assert property (i_req.rd |=> o_rvalid)
    else $error("read not answered");
  idle_quiet_a: assert property (!i_req.rd |=> !o_rvalid && o_rdata == 16'h0000)
    else $error("read output without read");
  unmapped_zero_a: assert property (i_req.rd && !(i_req.addr inside {8'h14, 8'h22, 8'h23}) |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  slot_a_a: assert property (i_req.wr && i_req.addr == 8'h14 |-> ##2 o_slot_a == dec(w2[1:0], w2[7:4]))
    else $error("slot a decode wrong");
  slot_b_a: assert property (i_req.wr && i_req.addr == 8'h14 |-> ##2 o_slot_b == dec(w2[3:2], w2[11:8]))
    else $error("slot b decode wrong");
  emit3_cfg_a: assert property (i_req.wr && i_req.addr == 8'h22 |-> ##2 o_emitter3 == {w2[13], w2[6:0]})
    else $error("emitter 3 settings wrong");
  emit1_cfg_a: assert property (i_req.wr && i_req.addr == 8'h23 |-> ##2 o_emitter1 == {w2[13], w2[6:0]})
    else $error("emitter 1 settings wrong");
  emit_hold_a: assert property (!(i_req.wr && i_req.addr == 8'h22) [*3] |=> $stable(o_emitter3))
    else $error("emitter 3 changed without write");
  cover property (i_req.wr && i_req.addr == 8'h14);
  cover property (i_req.rd && i_req.addr == 8'h22);
  cover property (i_req.rd && i_req.addr == 8'h15);
endmodule // lscr_top_asserts
bind lscr_top lscr_top_asserts u_chk (.i_clk, .i_arst_n, .i_req, .o_rdata, .o_rvalid, .o_slot_a, .o_slot_b,
  .o_emitter3, .o_emitter1);
`default_nettype wire

/* File: dv/lscr_top_test.sv */
// Purpose: Self-checking bench for the slot control register bank
// Assumes: Inputs change on the falling edge
// Notes:   Reserved bits written as software must
`timescale 1ns/1ps
`default_nettype none
module lscr_top_test;
  logic                 i_clk = 1'b0;
  logic                 i_arst_n = 1'b0;
  lscr_pkg::lscr_req_t  i_req = '0;
  logic [15:0]          o_rdata;
  logic                 o_rvalid;
  lscr_pkg::lscr_slot_t o_slot_a, o_slot_b;
  lscr_pkg::lscr_drv_t  o_emitter3, o_emitter1;
  int                   err_count = 0, checks = 0, cyc = 0;
  always #20 i_clk = ~i_clk;
  lscr_top dut (.i_clk, .i_arst_n, .i_req, .o_rdata, .o_rvalid, .o_slot_a, .o_slot_b, .o_emitter3, .o_emitter1);
  task automatic give_verdict;
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_req = '{wr: w, rd: !w, addr: a, wdata: w ? d : 16'h0000};
    @(negedge i_clk);
    i_req = '0;
    if (!w) cmp("rdata", d, o_rdata);
    if (!w) cmp("rvalid", 16'h0001, {15'h0, o_rvalid});
    @(negedge i_clk);
  endtask
  task automatic t_reset;
    acc(1'b0, 8'h14, 16'h0541);
    acc(1'b0, 8'h22, 16'h3000);
    acc(1'b0, 8'h23, 16'h3000);
    cmp("slot_a", 16'h0044, o_slot_a);
    cmp("slot_b", 16'h0015, o_slot_b);
    cmp("emit3", 16'h0080, o_emitter3);
    cmp("emit1", 16'h0080, o_emitter1);
  endtask
  task automatic t_codes;
    logic [15:0] d;
    for (int c = 0; c < 4; c++) begin
      d = {4'h0, 4'(12 - c), 4'(c + 3), 2'(3 - c), 2'(c)};
      acc(1'b1, 8'h14, d);
      cmp("slot_a", {7'h0, (c == 0) ? 4'h0 : 4'(1 << c), c == 0, 4'(c + 3)}, o_slot_a);
      cmp("slot_b", {7'h0, (c == 3) ? 4'h0 : 4'(1 << (3 - c)), c == 3, 4'(12 - c)}, o_slot_b);
      acc(1'b0, 8'h14, d);
    end
  endtask
  task automatic t_emit;
    acc(1'b1, 8'h22, 16'h107f);
    acc(1'b1, 8'h23, 16'h3050);
    cmp("emit3", 16'h007f, o_emitter3);
    cmp("emit1", 16'h00d0, o_emitter1);
    acc(1'b0, 8'h22, 16'h107f);
    acc(1'b1, 8'h23, 16'h107a);
    cmp("emit1", 16'h007a, o_emitter1);
    acc(1'b0, 8'h23, 16'h107a);
  endtask
  task automatic t_unmapped;
    acc(1'b1, 8'h15, 16'hffff);
    acc(1'b0, 8'h15, 16'h0000);
    acc(1'b0, 8'h14, 16'h0963);
  endtask
  task automatic t_midreset;
    acc(1'b1, 8'h22, 16'h1005);
    @(negedge i_clk);
    i_arst_n = 1'b0;
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b1;
    t_reset;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    i_arst_n = 1'b1;
    t_reset;
    t_codes;
    t_emit;
    t_unmapped;
    t_midreset;
    give_verdict;
  end
endmodule // lscr_top_test
`default_nettype wire
